// *** logic/vpe_voltage_protect.sv ***
// Under/overvoltage and phase reversal protection with register port
`timescale 1ns/100ps
`include "vpe_defs.svh"
module vpe_voltage_protect #(
   parameter int TICK_CYC = `VPE_TICK_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [4:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // Measurements and motor state
   input wire vpe_pkg::vpe_meas_s meas,
   input wire logic motor_running,
   input wire logic motor_starting,
   input wire logic speed_two,
   // Pins
   input wire logic breaker_closed,
   input wire logic metering_fitted,
   // Outputs
   output vpe_pkg::vpe_relay_s relays,
   output logic start_block,
   output logic [1:0] alarm_event
);
   // ************************************************************
   // State
   // ************************************************************
   vpe_pkg::vpe_state_s st_q, st_d;
   // Per-phase line-to-line magnitude times 100
   logic [2:0][22:0] v100;
   // Voltage level of each pickup times rated
   logic [23:0] lvl_uva, lvl_uvt, lvl_ova, lvl_ovt;
   // Per-stage pickup, expiry and next values
   logic [4:0] pick, expire, op_nx;
   logic [4:0][11:0] cnt_nx;
   // Qualifiers
   logic enable, stopped, uv_ok, v_high, i_armed;
   logic [15:0] flc;
   logic seq_i, rev;
   logic [2:0] uv_a, uv_t, ov_a, ov_t;
   logic clr;

   // ************************************************************
   // Measurement compare
   // ************************************************************
   // Only line-to-line inputs exist, whatever the sensor wiring
   assign v100[0] = meas.v_ab * 7'h64;
   assign v100[1] = meas.v_bc * 7'h64;
   assign v100[2] = meas.v_ca * 7'h64;
   // Threshold held in hundredths, scaled by nameplate voltage
   assign lvl_uva = (motor_starting ? st_q.uvs[7:0] : st_q.uvr[7:0])
      * st_q.rated;
   assign lvl_uvt = (motor_starting ? st_q.uvs[15:8] : st_q.uvr[15:8])
      * st_q.rated;
   assign lvl_ova = st_q.ov[7:0] * st_q.rated;
   assign lvl_ovt = st_q.ov[15:8] * st_q.rated;

   // Per-phase compare, any phase qualifies
   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_ph
         assign uv_a[p] = {1'b0, v100[p]} < lvl_uva;
         assign uv_t[p] = {1'b0, v100[p]} < lvl_uvt;
         assign ov_a[p] = {1'b0, v100[p]} > lvl_ova;
         assign ov_t[p] = {1'b0, v100[p]} > lvl_ovt;
      end
   endgenerate

   // ************************************************************
   // Qualifiers
   // ************************************************************
   // Voltage elements need the option and a wiring setting
   assign enable = st_q.opt_s[1]
      && (st_q.cfg[`VPE_CFG_VTW_LO+1:`VPE_CFG_VTW_LO] != 2'h0);
   // Stopped: no current and breaker open
   assign stopped = (meas.i_mag == 16'h0000) && !st_q.brk_s[1];
   // Stopped motor inhibits only when the setting says No
   assign uv_ok = !stopped || st_q.cfg[`VPE_CFG_UVSTOP];
   // All three above half rated selects voltage rotation
   // Per phase: v*2 > rated, so no divider is needed
   logic [2:0] vh;
   generate
      for (p = 0; p < 3; p++) begin : g_vh
         assign vh[p] = {meas.v_ab, 1'b0} > 17'(st_q.rated)
            && p == 0 || {meas.v_bc, 1'b0} > 17'(st_q.rated) && p == 1
            || {meas.v_ca, 1'b0} > 17'(st_q.rated) && p == 2;
      end
   endgenerate
   // One low phase drops back to the current path
   assign v_high = &vh;
   // Load setting of the active speed
   assign flc = (st_q.cfg[`VPE_CFG_TWOSPD] && speed_two)
      ? st_q.flc2 : st_q.flc1;
   // Current above 5% of full load current: i*20 > flc
   // One spare bit keeps a full-scale current from wrapping the sum
   assign i_armed = ({1'b0, meas.i_mag, 4'h0} + {3'h0, meas.i_mag, 2'h0})
      > {5'h00, flc};
   // Current sequence reference per speed
   assign seq_i = (st_q.cfg[`VPE_CFG_TWOSPD] && speed_two)
      ? st_q.cfg[`VPE_CFG_SEQ2] : st_q.cfg[`VPE_CFG_SEQ1];
   // Voltage path ignores currents and speed
   assign rev = v_high ? (meas.v_rot != st_q.cfg[`VPE_CFG_SEQ1])
      : (i_armed && meas.i_rot != seq_i);

   // Pickup per stage: uv alarm, uv trip, ov alarm, ov trip, reversal
   assign pick[0] = enable && uv_ok && (|uv_a);
   assign pick[1] = enable && uv_ok && (|uv_t);
   assign pick[2] = enable && (|ov_a);
   assign pick[3] = enable && (|ov_t);
   assign pick[4] = rev;
   // Latched clear strobe
   assign clr = wr && addr == `VPE_A_CMD && wdata[`VPE_CMD_CLR];

   // ************************************************************
   // Stage timers, one per stage
   // ************************************************************
   genvar k;
   generate
      for (k = 0; k < 5; k++) begin : g_stg
         logic [11:0] dly;
         logic on;
         // Reversal uses a fixed delay inside the trip window
         assign dly = (k == 4) ? `VPE_REV_TICKS : st_q.stg[k].dly;
         assign on = pick[k] && st_q.stg[k].mode != vpe_pkg::VPE_OFF;
         assign expire[k] = on && st_q.cnt[k] >= dly;
         // Counter restarts whenever pickup drops
         always_comb begin
            if (!on) begin
               cnt_nx[k] = 12'h000;
            end else if (st_q.tick && st_q.cnt[k] < dly) begin
               cnt_nx[k] = st_q.cnt[k] + 12'h001;
            end else begin
               cnt_nx[k] = st_q.cnt[k];
            end
         end
         // Operation: latched holds until clear, expiry wins
         always_comb begin
            case (st_q.stg[k].mode)
               vpe_pkg::VPE_LATCH: begin
                  op_nx[k] = expire[k] || (st_q.op[k] && !clr);
               end
               vpe_pkg::VPE_UNLATCH: begin
                  op_nx[k] = expire[k];
               end
               default: begin
                  op_nx[k] = 1'b0;
               end
            endcase
         end
      end
   endgenerate

   // ************************************************************
   // Next state
   // ************************************************************
   // Register writes, timers, sync and outputs
   always_comb begin
      st_d = st_q;
      // Pin synchronisers
      st_d.brk_s = {st_q.brk_s[0], breaker_closed};
      st_d.opt_s = {st_q.opt_s[0], metering_fitted};
      // Shared 100 ms tick
      if (st_q.pre >= 23'(TICK_CYC - 1)) begin
         st_d.pre = 23'h000000;
         st_d.tick = 1'b1;
      end else begin
         st_d.pre = st_q.pre + 23'h000001;
         st_d.tick = 1'b0;
      end
      st_d.cnt = cnt_nx;
      st_d.op = op_nx;
      // Writes; pickups in hundredths, delays in tenths
      if (wr) begin
         case (addr)
            `VPE_A_CFG: st_d.cfg = wdata;
            `VPE_A_RATED: st_d.rated = wdata;
            `VPE_A_FLC1: st_d.flc1 = wdata;
            `VPE_A_FLC2: st_d.flc2 = wdata;
            `VPE_A_UVSTART: st_d.uvs = wdata;
            `VPE_A_UVRUN: st_d.uvr = wdata;
            `VPE_A_OVLVL: st_d.ov = wdata;
            default: begin
               // Stage control and delay words
               for (int i = 0; i < 5; i++) begin
                  if (addr == `VPE_A_CTL0 + 5'(i)) begin
                     st_d.stg[i].mode = vpe_pkg::vpe_mode_e'(wdata[1:0]);
                     st_d.stg[i].rly = wdata[4:2];
                     st_d.stg[i].ev = wdata[5];
                  end
                  if (i < 4 && addr == `VPE_A_DLY0 + 5'(i)) begin
                     st_d.stg[i].dly = wdata[11:0];
                  end
               end
            end
         endcase
      end
      // Read data stands one cycle after the strobe
      st_d.rdata = 16'h0000;
      if (rd) begin
         case (addr)
            `VPE_A_CFG: st_d.rdata = st_q.cfg;
            `VPE_A_RATED: st_d.rdata = st_q.rated;
            `VPE_A_FLC1: st_d.rdata = st_q.flc1;
            `VPE_A_FLC2: st_d.rdata = st_q.flc2;
            `VPE_A_UVSTART: st_d.rdata = st_q.uvs;
            `VPE_A_UVRUN: st_d.rdata = st_q.uvr;
            `VPE_A_OVLVL: st_d.rdata = st_q.ov;
            `VPE_A_STATUS: st_d.rdata = {6'h00, stopped, enable,
               3'h0, st_q.op};
            default: begin
               for (int i = 0; i < 5; i++) begin
                  if (addr == `VPE_A_CTL0 + 5'(i)) begin
                     st_d.rdata = {10'h000, st_q.stg[i].ev,
                        st_q.stg[i].rly, st_q.stg[i].mode};
                  end
                  if (i < 4 && addr == `VPE_A_DLY0 + 5'(i)) begin
                     st_d.rdata = {4'h0, st_q.stg[i].dly};
                  end
               end
            end
         endcase
      end
      // Relay map: bit0 main, bit1 aux one, bit2 aux two
      st_d.rly.alarm = (op_nx[0] && st_q.stg[0].rly[0])
         || (op_nx[2] && st_q.stg[2].rly[0]);
      st_d.rly.trip = (op_nx[1] && st_q.stg[1].rly[0])
         || (op_nx[3] && st_q.stg[3].rly[0])
         || (op_nx[4] && st_q.stg[4].rly[0]);
      st_d.rly.aux_one = 1'b0;
      st_d.rly.aux_two = 1'b0;
      for (int i = 0; i < 5; i++) begin
         st_d.rly.aux_one = st_d.rly.aux_one
            || (op_nx[i] && st_q.stg[i].rly[1]);
         st_d.rly.aux_two = st_d.rly.aux_two
            || (op_nx[i] && st_q.stg[i].rly[2]);
      end
      // Reversal trip also blocks starting
      st_d.start_block = op_nx[4];
      // Event pulse on each new alarm operation when enabled
      st_d.evt[0] = op_nx[0] && !st_q.op[0] && st_q.stg[0].ev;
      st_d.evt[1] = op_nx[2] && !st_q.op[2] && st_q.stg[2].ev;
   end

   // ************************************************************
   // Registers
   // ************************************************************
   // Defaults per stage applied on reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.rated <= `VPE_RST_RATED;
         st_q.flc1 <= `VPE_RST_FLC;
         st_q.flc2 <= `VPE_RST_FLC;
         st_q.uvs <= `VPE_RST_UV;
         st_q.uvr <= `VPE_RST_UV;
         st_q.ov <= `VPE_RST_OV;
         for (int i = 0; i < 5; i++) begin
            st_q.stg[i].rly <= 3'(`VPE_RST_CTL >> 2);
            st_q.stg[i].dly <= (i % 2 == 0) ? `VPE_RST_DLY_ALM
               : `VPE_RST_DLY_TRP;
         end
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flops
   assign rdata = st_q.rdata;
   assign relays = st_q.rly;
   assign start_block = st_q.start_block;
   assign alarm_event = st_q.evt;
endmodule

// *** common/vpe_defs.svh ***
// Offsets, field positions, reset values and timing counts of the voltage elements
`ifndef VPE_DEFS_SVH
`define VPE_DEFS_SVH
// ************************************************************
// Register word offsets
// ************************************************************
`define VPE_A_CFG 5'h00
`define VPE_A_RATED 5'h01
`define VPE_A_FLC1 5'h02
`define VPE_A_FLC2 5'h03
`define VPE_A_UVSTART 5'h04
`define VPE_A_UVRUN 5'h05
`define VPE_A_OVLVL 5'h06
`define VPE_A_CTL0 5'h07
`define VPE_A_DLY0 5'h0C
`define VPE_A_STATUS 5'h10
`define VPE_A_CMD 5'h11
// ************************************************************
// Field positions
// ************************************************************
`define VPE_CFG_UVSTOP 0
`define VPE_CFG_TWOSPD 1
`define VPE_CFG_SEQ1 2
`define VPE_CFG_SEQ2 3
`define VPE_CFG_VTW_LO 4
`define VPE_CMD_CLR 0
// ************************************************************
// Reset values
// ************************************************************
`define VPE_RST_CFG 16'h0000
`define VPE_RST_RATED 16'h1000
`define VPE_RST_FLC 16'h0100
`define VPE_RST_UV 16'h5055
`define VPE_RST_OV 16'h6E69
`define VPE_RST_CTL 16'h0004
`define VPE_RST_DLY_ALM 12'h01E
`define VPE_RST_DLY_TRP 12'h00A
// ************************************************************
// Timing
// ************************************************************
`define VPE_CLK_HZ 50000000
`define VPE_TICK_MS 100
`define VPE_TICK_CYC (`VPE_CLK_HZ / 1000 * `VPE_TICK_MS)
`define VPE_REV_MS 600
`define VPE_REV_TICKS 12'(`VPE_REV_MS / `VPE_TICK_MS)
`endif

// *** common/vpe_pkg.sv ***
// Types shared by the voltage protection elements
package vpe_pkg;
   // Stage output mode
   typedef enum logic [1:0] {
      VPE_OFF = 2'h0,
      VPE_LATCH = 2'h1,
      VPE_UNLATCH = 2'h2
   } vpe_mode_e;
   // Per-stage settings
   typedef struct packed {
      logic [11:0] dly;
      logic ev;
      logic [2:0] rly;
      vpe_mode_e mode;
   } vpe_stage_s;
   // Measurement bundle, same clock domain
   typedef struct packed {
      logic [15:0] v_ab;
      logic [15:0] v_bc;
      logic [15:0] v_ca;
      logic [15:0] i_mag;
      logic v_rot;
      logic i_rot;
   } vpe_meas_s;
   // Relay drive bundle
   typedef struct packed {
      logic trip;
      logic alarm;
      logic aux_one;
      logic aux_two;
   } vpe_relay_s;
   // Whole module state
   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] rated;
      logic [15:0] flc1;
      logic [15:0] flc2;
      logic [15:0] uvs;
      logic [15:0] uvr;
      logic [15:0] ov;
      vpe_stage_s [4:0] stg;
      logic [4:0][11:0] cnt;
      logic [4:0] op;
      logic [22:0] pre;
      logic tick;
      logic [1:0] brk_s;
      logic [1:0] opt_s;
      logic [15:0] rdata;
      vpe_relay_s rly;
      logic start_block;
      logic [1:0] evt;
   } vpe_state_s;
endpackage

// *** tb/vpe_vp_asserts.sv ***
// Port-level assertions for the voltage protection block
`timescale 1ns/100ps
module vpe_vp_chk #(
   parameter int TICK_CYC = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [4:0] addr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   // Measurements and outputs
   input wire vpe_pkg::vpe_meas_s meas,
   input wire logic metering_fitted,
   input wire vpe_pkg::vpe_relay_s relays,
   input wire logic start_block,
   input wire logic [1:0] alarm_event
);
   // ********************
   // Checks
   // ********************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // All three line voltages gone
   logic dead;
   assign dead = (meas.v_ab | meas.v_bc | meas.v_ca) == 16'h0000;
   // Causes held long enough to cross the pin synchronisers
   sequence s_meter_off;
      (!metering_fitted) [*5];
   endsequence
   sequence s_dead;
      dead [*4];
   endsequence
   sequence s_no_load;
      (dead && meas.i_mag == 16'h0000) [*4];
   endsequence
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data without a read");
   unmapped_read_a: assert property (rd && addr > 5'h11 |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   uv_event_pulse_a: assert property (alarm_event[0] |=> !alarm_event[0])
      else $error("undervoltage event too long");
   ov_event_pulse_a: assert property (alarm_event[1] |=> !alarm_event[1])
      else $error("overvoltage event too long");
   meter_event_a: assert property (s_meter_off |-> alarm_event == 2'h0)
      else $error("event without metering");
   meter_alarm_a: assert property (s_meter_off |-> !$rose(relays.alarm))
      else $error("alarm without metering");
   ov_dead_bus_a: assert property (s_dead |-> !alarm_event[1])
      else $error("overvoltage on a dead bus");
   reversal_unarmed_a: assert property (s_no_load |-> !$rose(start_block))
      else $error("reversal with nothing measured");
endmodule
bind vpe_voltage_protect vpe_vp_chk #(
   .TICK_CYC(TICK_CYC)
) vpe_vp_chk_inst (
   .clk(clk), .rst_n(rst_n), .addr(addr), .rd(rd), .rdata(rdata), .meas(meas),
   .metering_fitted(metering_fitted), .relays(relays), .start_block(start_block),
   .alarm_event(alarm_event)
);

// *** tb/vpe_plant.sv ***
// Motor starter and measurement model facing the voltage protection block
`timescale 1ns/100ps
module vpe_plant (
   // Bench commands: 0 stopped, 1 starting, 2 running
   input wire logic [1:0] state,
   input wire logic bus_on,
   // Percent of rated voltage on two phases, percent of load current
   input wire logic [7:0] ca_pct,
   input wire logic [7:0] bc_pct,
   input wire logic [7:0] i_pct,
   // Measured rotations
   input wire logic v_rot,
   input wire logic i_rot,
   // Towards the relay
   output vpe_pkg::vpe_meas_s meas,
   output logic motor_running,
   output logic motor_starting,
   output logic breaker_closed
);
   // ********************
   // Scaling
   // ********************
   // Nameplate figures match the relay's reset settings
   localparam logic [31:0] RATED = 32'h1000;
   localparam logic [31:0] FLC = 32'h0100;
   // A dead bus reads zero on every phase, never the last value
   assign meas.v_ab = bus_on ? RATED[15:0] : 16'h0000;
   assign meas.v_bc = bus_on ? 16'(RATED * bc_pct / 32'h64) : 16'h0000;
   assign meas.v_ca = bus_on ? 16'(RATED * ca_pct / 32'h64) : 16'h0000;
   // Stopped means starter open and no current
   assign meas.i_mag = (state == 2'h0) ? 16'h0000 : 16'(FLC * i_pct / 32'h64);
   assign breaker_closed = state != 2'h0;
   assign motor_starting = state == 2'h1;
   assign motor_running = state == 2'h2;
   assign meas.v_rot = v_rot;
   assign meas.i_rot = i_rot;
endmodule

// *** tb/tb_vpe_voltage_protect.sv ***
// Self-checking bench for the voltage protection block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin \
   n_compared++; \
   if ((got) !== (exp)) begin \
      fails++; \
      $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
   end \
end
module tb_vpe_voltage_protect;
   // ********************
   // Signals
   // ********************
   logic clk = 1'b0;
   logic rst_n, wr, rd, metering_fitted, speed_two, start_block, bus_on, v_rot, i_rot;
   logic motor_running, motor_starting, breaker_closed;
   logic [4:0] addr;
   logic [15:0] wdata, rdata, d;
   logic [1:0] alarm_event, state, ev_seen;
   logic [7:0] ca_pct, bc_pct, i_pct;
   logic [3:0] rly_at;
   vpe_pkg::vpe_meas_s meas;
   vpe_pkg::vpe_relay_s relays;
   int fails = 0;
   int n_compared = 0;
   int t_alm, t_trp, t_blk;
   // Reset image of words 0x00 to 0x10
   logic [15:0] exp_rst [17] = '{16'h0000, 16'h1000, 16'h0100, 16'h0100, 16'h5055,
      16'h5055, 16'h6E69, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h001E,
      16'h000A, 16'h001E, 16'h000A, 16'h0200};
   // 50 MHz clock
   always #10 clk = ~clk;
   vpe_voltage_protect #(.TICK_CYC(10)) vpe_voltage_protect_inst (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .meas(meas), .motor_running(motor_running),
      .motor_starting(motor_starting), .speed_two(speed_two),
      .breaker_closed(breaker_closed), .metering_fitted(metering_fitted),
      .relays(relays), .start_block(start_block), .alarm_event(alarm_event));
   vpe_plant vpe_plant_inst (
      .state(state), .bus_on(bus_on), .ca_pct(ca_pct), .bc_pct(bc_pct), .i_pct(i_pct),
      .v_rot(v_rot), .i_rot(i_rot), .meas(meas), .motor_running(motor_running),
      .motor_starting(motor_starting), .breaker_closed(breaker_closed));
   // ********************
   // Tasks
   // ********************
   // One-cycle write; the gap edge keeps strobes single-assigned per step
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Bounded watch: first cycle of alarm, trip and start block, -1 if never seen
   task automatic run(input int n);
      t_alm = -1;
      t_trp = -1;
      t_blk = -1;
      ev_seen = 2'h0;
      for (int c = 1; c <= n; c++) begin
         @(posedge clk);
         #1 ev_seen = ev_seen | alarm_event;
         if (relays.alarm === 1'b1 && t_alm < 0) begin
            t_alm = c;
            rly_at = relays;
         end
         if (relays.trip === 1'b1 && t_trp < 0) t_trp = c;
         if (start_block === 1'b1 && t_blk < 0) t_blk = c;
      end
   endtask
   task automatic give_verdict;
      if (fails == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ********************
   // Sequence
   // ********************
   initial begin
      rst_n = 1'b0;
      addr = 5'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      metering_fitted = 1'b0;
      speed_two = 1'b0;
      state = 2'h0;
      bus_on = 1'b0;
      ca_pct = 8'h64;
      bc_pct = 8'h64;
      i_pct = 8'h64;
      v_rot = 1'b0;
      i_rot = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 17; k++) begin
         rd_reg(5'(k), d);
         `CHK("reset word", exp_rst[k], d)
      end
      rd_reg(5'h1F, d);
      `CHK("unmapped read", 16'h0000, d)
      wr_reg(5'h00, 16'h0010);
      rd_reg(5'h10, d);
      `CHK("enable no meter", 1'b0, d[8])
      @(posedge clk);
      metering_fitted <= 1'b1;
      wr_reg(5'h00, 16'h0000);
      rd_reg(5'h10, d);
      `CHK("enable no wiring", 1'b0, d[8])
      wr_reg(5'h00, 16'h0010);
      rd_reg(5'h10, d);
      `CHK("enable", 1'b1, d[8])
      // Stopped motor, unlatched alarm on main and aux one with events
      wr_reg(5'h07, 16'h002E);
      wr_reg(5'h0C, 16'h0002);
      @(posedge clk);
      bus_on <= 1'b1;
      ca_pct <= 8'h50;
      run(40);
      `CHK("stopped inhibit", -1, t_alm)
      wr_reg(5'h00, 16'h0011);
      run(40);
      `CHK("alarm delay", 1'b1, t_alm inside {[6:24]})
      `CHK("alarm relays", 4'b0110, rly_at)
      `CHK("alarm event", 2'b01, ev_seen)
      @(posedge clk);
      ca_pct <= 8'h64;
      run(4);
      `CHK("unlatched drop", 1'b0, relays.alarm)
      // Starting pickup sits below the running one
      wr_reg(5'h04, 16'h5050);
      @(posedge clk);
      state <= 2'h1;
      ca_pct <= 8'h52;
      run(40);
      `CHK("start pickup", -1, t_alm)
      @(posedge clk);
      state <= 2'h2;
      run(40);
      `CHK("run pickup", 1'b1, t_alm > 0)
      @(posedge clk);
      ca_pct <= 8'h64;
      // Overvoltage: event-only alarm, latched trip, zero delays
      wr_reg(5'h09, 16'h0022);
      wr_reg(5'h0E, 16'h0000);
      wr_reg(5'h0A, 16'h0005);
      wr_reg(5'h0F, 16'h0000);
      @(posedge clk);
      bc_pct <= 8'h6E;
      run(20);
      `CHK("ov at pickup", -1, t_trp)
      `CHK("ov alarm event", 2'b10, ev_seen)
      `CHK("alarm unassigned", -1, t_alm)
      @(posedge clk);
      bc_pct <= 8'h6F;
      run(10);
      `CHK("ov zero delay", 1'b1, t_trp inside {[1:4]})
      @(posedge clk);
      bc_pct <= 8'h64;
      run(10);
      `CHK("latched hold", 1'b1, relays.trip)
      wr_reg(5'h11, 16'h0001);
      run(3);
      `CHK("latched clear", 1'b0, relays.trip)
      // Reversal by voltage rotation; current rotation ignored
      wr_reg(5'h0B, 16'h0016);
      @(posedge clk);
      i_rot <= 1'b1;
      run(90);
      `CHK("currents ignored", -1, t_blk)
      @(posedge clk);
      v_rot <= 1'b1;
      run(90);
      `CHK("reversal delay", 1'b1, t_blk inside {[45:66]})
      `CHK("reversal trip", 1'b1, t_trp inside {[45:66]})
      `CHK("reversal aux two", 1'b1, relays.aux_two)
      `CHK("reversal no aux one", 1'b0, relays.aux_one)
      // Current rotation, speed two sequence set opposite
      @(posedge clk);
      v_rot <= 1'b0;
      bus_on <= 1'b0;
      i_pct <= 8'h04;
      wr_reg(5'h00, 16'h001A);
      run(90);
      `CHK("below arming", -1, t_blk)
      @(posedge clk);
      i_pct <= 8'h0A;
      speed_two <= 1'b1;
      run(90);
      `CHK("speed two sequence", -1, t_blk)
      @(posedge clk);
      speed_two <= 1'b0;
      run(90);
      `CHK("speed one sequence", 1'b1, t_blk inside {[45:66]})
      give_verdict();
   end
endmodule
